//--- hdl/diag_pkg.sv
package diag_pkg;

    // Serial word
    localparam int WORD_BITS = 11;
    localparam int CHANNELS = 4;
    localparam logic IDLE_BIT = 1'b1;

    // Field positions inside the serial word, bit 1 of the word at index 0
    localparam int POS_LOAD_ERR = 0;
    localparam int POS_SW_STATE = 4;
    localparam int POS_WARN_N = 8;
    localparam int POS_TSD_N = 9;
    localparam int POS_OVER_VOLT = 10;

    // Reset values
    localparam logic [WORD_BITS-1:0] WORD_RST = 11'h7FF;
    localparam logic [CHANNELS-1:0] GATE_RST = 4'h0;

    // Timing
    localparam int CLK_FREQ_MHZ = 250;
    localparam int FLAG_DELAY_US = 75;
    localparam int ENABLE_DELAY_US = 30;
    localparam int FLAG_DELAY_CYC = FLAG_DELAY_US * CLK_FREQ_MHZ;
    localparam int ENABLE_DELAY_CYC = ENABLE_DELAY_US * CLK_FREQ_MHZ;
    localparam int CNT_W = 16;
    localparam int SYNC_STAGES = 2;

    // Pin inputs, all asynchronous to ref_clk
    typedef struct packed {
        logic enable;
        logic cs_n;
        logic sclk;
        logic tsd_pin;
        logic [CHANNELS-1:0] sw_cmd;
        logic [CHANNELS-1:0] load_fault;
        logic temp_warn;
        logic temp_hot;
        logic temp_cool;
        logic over_volt;
    } pin_in_t;

    // Diagnostic word, last field is the first bit shifted out
    typedef struct packed {
        logic over_volt;
        logic tsd_n;
        logic warn_n;
        logic [CHANNELS-1:0] sw_state;
        logic [CHANNELS-1:0] load_err;
    } diag_word_t;

    // Open-drain or three-state pin driven by the block
    typedef struct packed {
        logic o;
        logic oe_n;
    } pin_out_t;

    typedef enum logic [1:0] {
        PWR_SLEEP,
        PWR_ARMING,
        PWR_ACTIVE
    } pwr_state_t;

endpackage

//--- hdl/sync_2ff.sv
`timescale 1ns/100ps
module sync_2ff #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

//--- hdl/quad_switch_diag.sv
`timescale 1ns/100ps
module quad_switch_diag #(
    parameter int FLAG_DELAY_CYCLES = diag_pkg::FLAG_DELAY_CYC,
    parameter int ENABLE_DELAY_CYCLES = diag_pkg::ENABLE_DELAY_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Asynchronous pins and comparator levels
    input wire diag_pkg::pin_in_t pins,
    // Serial data pin
    output diag_pkg::pin_out_t sdata,
    // General fault flag, open drain
    output diag_pkg::pin_out_t fault_n,
    // Thermal shutdown flag, open drain, read back through pins.tsd_pin
    output diag_pkg::pin_out_t tsd_n,
    // Switch gate drive
    output logic [diag_pkg::CHANNELS-1:0] gate_on
);
    import diag_pkg::*;

    // Advance a delay counter, saturating at the limit
    function automatic logic [CNT_W-1:0] count_step(input logic [CNT_W-1:0] cnt,
                                                    input logic [CNT_W-1:0] limit);
        count_step = (cnt >= limit) ? limit : cnt + 16'h0001;
    endfunction

    localparam logic [CNT_W-1:0] FLAG_LIMIT = CNT_W'(FLAG_DELAY_CYCLES);
    localparam logic [CNT_W-1:0] ARM_LIMIT = CNT_W'(ENABLE_DELAY_CYCLES);
    localparam logic [3:0] SHIFT_LIMIT = 4'(WORD_BITS);

    // Synchronised pins
    pin_in_t pin_s;

    sync_2ff #(
        .WIDTH($bits(pin_in_t))
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .async_in(pins),
        .sync_out(pin_s)
    );

    // Power state
    pwr_state_t pwr_r;
    pwr_state_t pwr_nxt;
    logic [CNT_W-1:0] arm_cnt_r;
    logic [CNT_W-1:0] arm_cnt_nxt;
    wire awake = pwr_r != PWR_SLEEP;
    wire armed = pwr_r == PWR_ACTIVE;
    wire arm_done = arm_cnt_r >= ARM_LIMIT;

    // Thermal and shutdown state
    logic tsd_r;
    logic tsd_nxt;
    wire shutdown = ~pin_s.tsd_pin;
    logic [CHANNELS-1:0] gate_nxt;

    // Serial link
    logic sclk_d_r;
    logic [WORD_BITS-1:0] shift_r;
    logic [WORD_BITS-1:0] shift_nxt;
    logic [3:0] bits_out_r;
    logic [3:0] bits_out_nxt;
    wire sclk_fall = sclk_d_r & ~pin_s.sclk;
    wire selected = awake & ~pin_s.cs_n;
    wire shift_now = selected & sclk_fall;
    wire word_done = bits_out_r >= SHIFT_LIMIT;

    // Fault flag
    logic [CNT_W-1:0] flag_cnt_r;
    logic [CNT_W-1:0] flag_cnt_nxt;
    logic flag_r;
    logic flag_nxt;

    // Diagnostic word
    diag_word_t diag;
    wire [CHANNELS-1:0] cmd_on = armed ? pin_s.sw_cmd : GATE_RST;
    wire [CHANNELS-1:0] forced_off = cmd_on & ~gate_on;
    wire any_error = (|diag.load_err) | ~diag.warn_n | ~diag.tsd_n | diag.over_volt;

    // Commanded-on but held off shows as a switch error
    assign diag.load_err = pin_s.load_fault | forced_off;
    assign diag.sw_state = cmd_on;
    assign diag.warn_n = ~(pin_s.temp_warn | shutdown);
    assign diag.tsd_n = ~shutdown;
    assign diag.over_volt = pin_s.over_volt;

    // Power sequencing
    always_comb begin
        pwr_nxt = pwr_r;
        arm_cnt_nxt = arm_cnt_r;
        if (!pin_s.enable) begin
            pwr_nxt = PWR_SLEEP;
            arm_cnt_nxt = '0;
        end else begin
            unique case (pwr_r)
                PWR_SLEEP: begin
                    pwr_nxt = PWR_ARMING;
                    arm_cnt_nxt = '0;
                end
                PWR_ARMING: begin
                    arm_cnt_nxt = count_step(arm_cnt_r, ARM_LIMIT);
                    if (arm_done) begin
                        pwr_nxt = PWR_ACTIVE;
                    end
                end
                PWR_ACTIVE: begin
                    arm_cnt_nxt = arm_cnt_r;
                end
                // Unused code falls back to sleep so the switches stay off
                default: begin
                    pwr_nxt = PWR_SLEEP;
                    arm_cnt_nxt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pwr_r <= PWR_SLEEP;
            arm_cnt_r <= '0;
        end else begin
            pwr_r <= pwr_nxt;
            arm_cnt_r <= arm_cnt_nxt;
        end
    end

    // Thermal shutdown with hysteresis; the flag pin level is what gates the switches,
    // so an external low acts exactly like an internal trip
    always_comb begin
        tsd_nxt = tsd_r;
        if (!awake) begin
            tsd_nxt = 1'b0;
        end else if (pin_s.temp_hot) begin
            tsd_nxt = 1'b1;
        end else if (pin_s.temp_cool) begin
            tsd_nxt = 1'b0;
        end
    end

    always_comb begin
        gate_nxt = GATE_RST;
        if (armed && !shutdown && !pin_s.over_volt) begin
            gate_nxt = pin_s.sw_cmd;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tsd_r <= 1'b0;
            gate_on <= GATE_RST;
        end else begin
            tsd_r <= tsd_nxt;
            gate_on <= gate_nxt;
        end
    end

    // Internal trip pulls the flag low straight from the trip state
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tsd_n <= '{o: 1'b0, oe_n: 1'b1};
        end else begin
            tsd_n <= '{o: 1'b0, oe_n: ~tsd_nxt};
        end
    end

    // Serial shift register
    always_comb begin
        shift_nxt = shift_r;
        bits_out_nxt = bits_out_r;
        if (!selected) begin
            shift_nxt = diag;
            bits_out_nxt = '0;
        end else if (shift_now) begin
            shift_nxt = {IDLE_BIT, shift_r[WORD_BITS-1:1]};
            bits_out_nxt = word_done ? bits_out_r : bits_out_r + 4'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sclk_d_r <= 1'b0;
            shift_r <= WORD_RST;
            bits_out_r <= '0;
        end else begin
            sclk_d_r <= pin_s.sclk;
            shift_r <= shift_nxt;
            bits_out_r <= bits_out_nxt;
        end
    end

    // Data pin; the first bit is out within a few cycles, well inside the host setup time
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sdata <= '{o: IDLE_BIT, oe_n: 1'b1};
        end else begin
            sdata <= '{o: shift_nxt[0], oe_n: ~selected};
        end
    end

    // Fault flag masking delay; a gap in the error restarts the delay
    always_comb begin
        flag_cnt_nxt = '0;
        flag_nxt = 1'b0;
        if (awake && any_error) begin
            flag_cnt_nxt = count_step(flag_cnt_r, FLAG_LIMIT);
            flag_nxt = flag_cnt_r >= FLAG_LIMIT;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            flag_cnt_r <= '0;
            flag_r <= 1'b0;
        end else begin
            flag_cnt_r <= flag_cnt_nxt;
            flag_r <= flag_nxt;
        end
    end

    // Pull-down only, never driven high
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            fault_n <= '{o: 1'b0, oe_n: 1'b1};
        end else begin
            fault_n <= '{o: 1'b0, oe_n: ~flag_nxt};
        end
    end

endmodule

//--- test/quad_switch_diag_sva.sv
`timescale 1ns/100ps
module quad_switch_diag_chk #(
    parameter int FLAG_DELAY_CYCLES = 20,
    parameter int ENABLE_DELAY_CYCLES = 10
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Pins
    input wire diag_pkg::pin_in_t pins,
    input wire diag_pkg::pin_out_t sdata,
    input wire diag_pkg::pin_out_t fault_n,
    input wire diag_pkg::pin_out_t tsd_n,
    input wire logic [diag_pkg::CHANNELS-1:0] gate_on
);
    import diag_pkg::*;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    logic [15:0] err_cnt;
    // Counted at the pins, so sync lag is margin
    wire any_err = |pins.load_fault | pins.temp_warn | pins.temp_hot
        | pins.over_volt | !pins.tsd_pin;
    wire err_clr = srst || !pins.enable || !any_err;
    always_ff @(posedge ref_clk) begin
        err_cnt <= err_clr ? 16'h0 : err_cnt + {15'h0, !err_cnt[15]};
    end
    a_data_released: assert property (pins.cs_n [*4] |-> sdata.oe_n)
        else $error("data driven");
    a_flag_open_drain: assert property (!fault_n.o && !tsd_n.o)
        else $error("flag high");
    a_flag_masked: assert property ($fell(fault_n.oe_n) |-> err_cnt >= FLAG_DELAY_CYCLES)
        else $error("flag early");
    a_flag_raised: assert property (err_cnt == FLAG_DELAY_CYCLES + 8 |-> !fault_n.oe_n)
        else $error("flag missing");
    a_flag_release: assert property ((err_cnt == 16'h0) [*6] |-> fault_n.oe_n)
        else $error("flag stuck");
    a_tsd_flag_fast: assert property ((pins.temp_hot && pins.enable) [*4] |-> !tsd_n.oe_n)
        else $error("tsd late");
    a_gates_forced_off: assert property (
        (!pins.tsd_pin || pins.over_volt) [*4] |-> gate_on == 4'h0)
        else $error("gate on");
    a_sleep_all_off: assert property (
        (!pins.enable) [*5] |-> gate_on == 4'h0 && sdata.oe_n && fault_n.oe_n)
        else $error("awake");
    cover property ($fell(sdata.oe_n));
    cover property ($fell(tsd_n.oe_n));
    cover property ($fell(fault_n.oe_n));
endmodule

//--- test/serial_host.sv
`timescale 1ns/100ps
module serial_host (
    // Frame control
    input wire logic go,
    input wire logic [7:0] gap,
    output logic done,
    output logic [11:0] word,
    // Link
    output logic cs_n,
    output logic sclk,
    input wire logic sd
);
    initial begin
        {cs_n, sclk, done, word} = 15'h4000;
    end
    // Clock idles low so the first rise reads bit one
    always @(posedge go) begin
        done = 1'b0;
        #1.3;
        cs_n = 1'b0;
        #(500 + gap);
        for (int i = 0; i < 12; i++) begin
            sclk = 1'b1;
            word[i] = sd;
            #62.5;
            sclk = 1'b0;
            #62.5;
        end
        cs_n = 1'b1;
        done = 1'b1;
    end
endmodule

//--- test/test_quad_switch_diag.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module test_quad_switch_diag;
    import diag_pkg::*;
    logic ref_clk = 1'b0, srst = 1'b1, go = 1'b0, enable = 1'b1, ext_low = 1'b0;
    logic hot = 1'b0, cool = 1'b1, warn = 1'b0, ov = 1'b0, sd_last = 1'b0, done, cs_n, sclk;
    logic [3:0] cmd = 4'h0, lf = 4'h0, gate_on;
    logic [7:0] gap = 8'h00;
    logic [11:0] word, exp_word;
    logic [11:0] exp_q[$];
    int mismatches = 0, comparisons = 0, seed = 17943;
    pin_out_t sdata, fault_n, tsd_n;
    pin_in_t pins;
    // Pull-up on the wire, never held high here
    wire tsd_wire = !(ext_low || !tsd_n.oe_n);
    // Released line shows the opposite of its last level
    wire sd = sdata.oe_n ? !sd_last : sdata.o;
    assign pins = {enable, cs_n, sclk, tsd_wire, cmd, lf, warn, hot, cool, ov};
    initial forever #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (!sdata.oe_n) sd_last <= sdata.o;
    quad_switch_diag #(.FLAG_DELAY_CYCLES(20), .ENABLE_DELAY_CYCLES(10)) quad_switch_diag_inst (
        .ref_clk(ref_clk), .srst(srst), .pins(pins), .sdata(sdata), .fault_n(fault_n),
        .tsd_n(tsd_n), .gate_on(gate_on));
    serial_host serial_host_inst (.go(go), .gap(gap), .done(done), .word(word),
        .cs_n(cs_n), .sclk(sclk), .sd(sd));
    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic frame(input logic shut);
        logic [3:0] le;
        repeat (40) @(posedge ref_clk);
        le = lf | ((shut || ov) ? cmd : 4'h0);
        `CHK("gates", (shut || ov) ? 4'h0 : cmd, gate_on)
        `CHK("fault", !(|le || warn || shut || ov), fault_n.oe_n)
        exp_q.push_back({1'b1, ov, !shut, !(warn || shut), cmd, le});
        go <= 1'b1;
        gap <= 8'($random(seed));
        repeat (250) @(posedge ref_clk);
        lf <= 4'($random(seed));
        go <= 1'b0;
        for (int k = 0; k < 500 && !done; k++) @(posedge ref_clk);
        `CHK("frame done", 1'b1, done)
    endtask
    always @(posedge done) begin
        exp_word = exp_q.pop_front();
        `CHK("word", exp_word, word)
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (30) @(posedge ref_clk);
        for (int n = 0; n < 8; n++) begin
            {warn, lf, cmd} <= 9'($random(seed));
            ov <= (n == 5);
            frame(1'b0);
        end
        $display("Random frames done");
        {ov, warn, hot, cool} <= 4'h6;
        frame(1'b1);
        hot <= 1'b0;
        frame(1'b1);
        {warn, cool} <= 2'h1;
        frame(1'b0);
        $display("Thermal done");
        ext_low <= 1'b1;
        frame(1'b1);
        ext_low <= 1'b0;
        $display("External shutdown done");
        {enable, lf, cmd} <= 9'h00F;
        repeat (10) @(posedge ref_clk);
        `CHK("sleep gates", 4'h0, gate_on)
        `CHK("sleep data", 1'b1, sdata.oe_n)
        enable <= 1'b1;
        repeat (9) @(posedge ref_clk);
        `CHK("arming gates", 4'h0, gate_on)
        frame(1'b0);
        $display("Sleep done");
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        wrap_up();
    end
endmodule
bind quad_switch_diag quad_switch_diag_chk #(.FLAG_DELAY_CYCLES(FLAG_DELAY_CYCLES),
    .ENABLE_DELAY_CYCLES(ENABLE_DELAY_CYCLES)) quad_switch_diag_chk_inst (.ref_clk(ref_clk),
    .srst(srst), .pins(pins), .sdata(sdata), .fault_n(fault_n), .tsd_n(tsd_n), .gate_on(gate_on));
